// *** rtl/hub_strap_power_clock_ctrl.v ***
// Strap decode, port power, pullup delay and clock select control for a 7-port hub
//
// Contract
// [R1] Seven ports self-powered, four bus-powered
// [R2] Pullup held off 15 ms after reset/strap change
// [R3] Memory strap high gives default identifiers
// [R4] Memory strap high: data pin selects gang
// [R5] Memory strap low: identifiers, gang from EEPROM
// [R6] Memory strap low: pins are EEPROM clock/data
// [R7] EEPROM pins can float for sharing
// [R8] Overcurrent drops power of affected port/gang
// [R9] Ganged: all enables together, any overcurrent
// [R10] Non-ganged: each port independent
// [R11] Overcurrent inputs filtered against spikes
// [R12] Power enables driven to both levels
// [R13] Clock strap low selects multiplier clock
// [R14] Clock strap high: direct 48 MHz, powerdown
// [R15] External oscillator stopped low in suspend
// [R16] Suspend status output; stop clock
// [R17] Three indicators for configured, power, disabled
// [R18] Slew rate follows attached device speed
// [R19] Configured indicator high when configured
// [R20] Power strap low means bus-powered
// [R21] Pullup floats during delay, then high
// [R22] Delay counter restarts on reset/strap change
`include "hub_ctrl_consts.vh"

module hub_strap_power_clock_ctrl #(
    parameter        PULLUP_DELAY = `PULLUP_DELAY_CYC,
    parameter [15:0] DEFAULT_VID  = 16'h1A2B,   // Arbitrary value
    parameter [15:0] DEFAULT_PID  = 16'h3C4D    // Arbitrary value
) (
    input  wire        pclk,                     // APB clock, 25 MHz
    input  wire        presetn,                  // Async reset, active low
    input  wire [7:0]  paddr,                    // APB address
    input  wire        psel,                     // APB select
    input  wire        penable,                  // APB enable
    input  wire        pwrite,                   // APB write
    input  wire [31:0] pwdata,                   // APB write data
    output reg  [31:0] prdata,                   // APB read data
    output reg         pready,                   // APB ready
    output reg         pslverr,                  // APB error
    input  wire        power_source_strap_n,     // Low = bus-powered
    input  wire        ext_memory_disable_strap, // High = no EEPROM
    input  wire        clock_mode_strap,         // High = direct 48 MHz
    input  wire [6:0]  overcurrent_in_n,         // Overcurrent, active low
    input  wire [6:0]  low_speed_attached,       // Attached device is low speed
    output reg         eeprom_serial_clock,      // EEPROM clock out
    output reg         eeprom_serial_clock_oe,   // EEPROM clock drive enable
    output reg         eeprom_serial_data_o,     // EEPROM data out
    output reg         eeprom_serial_data_oe,    // EEPROM data drive enable
    input  wire        eeprom_serial_data_i,     // EEPROM data in / gang select
    output reg  [6:0]  port_power_enable,        // Port power enables
    output reg         upstream_pullup_ctrl,     // Pullup level
    output reg         upstream_pullup_oe,       // Pullup drive enable
    output reg         core_clock_select,        // 1 = direct input clock
    output reg         clock_multiplier_pll_pd,  // Multiplier power down
    output reg         oscillator_pd,            // Oscillator cell power down
    output reg         suspend_status_out,       // Suspended
    output reg         hub_configured_led,       // Hub configured
    output reg         port_power_led,           // Some port powered
    output reg         port_disabled_led,        // Some port disabled
    output reg  [6:0]  slow_slew_enable          // Low-speed slew per port
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg  [3:0]  ctrl_q;
    reg  [6:0]  port_req_q;
    reg  [6:0]  port_dis_q;
    reg  [6:0]  oc_sticky_q;
    reg  [18:0] pullup_cnt_q;
    reg         pullup_done_q;
    reg         strap_prev_q;
    reg         strap_seen_q;
    reg         ee_start_q;
    reg         ganged_q;
    reg  [31:0] rdata_d;
    reg         rerr_d;

    wire [6:0]  oc_filt;
    wire        ee_clk;
    wire        ee_clk_oe;
    wire        ee_do;
    wire        ee_doe;
    wire        ee_busy;
    wire        ee_done;
    wire [47:0] ee_words;

    wire        wr_en  = psel & penable & pready & pwrite;
    wire        ext_on = ~ext_memory_disable_strap;

    // ----------------------------------------
    // Overcurrent filtering
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_oc
            overcurrent_filter #(
                .CNT_W (8)
            ) u_filt (
                .pclk    (pclk),
                .presetn (presetn),
                .oc_in_n (overcurrent_in_n[gi]), // see [R11]
                .oc_q    (oc_filt[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // EEPROM loader
    // ----------------------------------------
    eeprom_reader u_ee (
        .pclk        (pclk),
        .presetn     (presetn),
        .start       (ee_start_q),
        .release_bus (ctrl_q[`CTRL_EE_RELEASE] | ~ext_on), // see [R7]
        .data_i      (eeprom_serial_data_i),
        .ser_clk_q   (ee_clk),
        .clk_oe_q    (ee_clk_oe),
        .data_o_q    (ee_do),
        .data_oe_q   (ee_doe),
        .busy_q      (ee_busy),
        .done_q      (ee_done),
        .words_q     (ee_words)
    );

    // One load after reset, and again on software request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ee_start_q   <= 1'b0;
            strap_seen_q <= 1'b0;
        end else begin
            strap_seen_q <= 1'b1;
            ee_start_q   <= ext_on & ~ee_busy & // see [R5]
                            (~strap_seen_q | (wr_en && paddr == `REG_CTRL &&
                                              pwdata[`CTRL_EE_RELOAD]));
        end
    end

    // ----------------------------------------
    // Pin muxing for the shared terminals
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eeprom_serial_clock    <= 1'b0;
            eeprom_serial_clock_oe <= 1'b0;
            eeprom_serial_data_o   <= 1'b0;
            eeprom_serial_data_oe  <= 1'b0;
            ganged_q               <= 1'b0;
        end else begin
            // Clock pin is left undriven when no EEPROM is fitted
            eeprom_serial_clock    <= ee_clk & ext_on;      // see [R6]
            eeprom_serial_clock_oe <= ee_clk_oe & ext_on;   // see [R4]
            eeprom_serial_data_o   <= ee_do & ext_on;       // see [R6]
            eeprom_serial_data_oe  <= ee_doe & ext_on;      // see [R7]
            if (!ext_on)
                ganged_q <= eeprom_serial_data_i;           // see [R4]
            else if (ee_done)
                ganged_q <= ee_words[0];                    // see [R5]
        end
    end

    // ----------------------------------------
    // Pullup delay after reset or power strap change
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_cnt_q         <= 19'h00000;
            pullup_done_q        <= 1'b0;
            strap_prev_q         <= 1'b0;
            upstream_pullup_ctrl <= 1'b0;
            upstream_pullup_oe   <= 1'b0;
        end else begin
            strap_prev_q <= power_source_strap_n;
            // The first cycle after reset also counts as a change
            if (strap_prev_q != power_source_strap_n || !strap_seen_q) begin
                pullup_cnt_q  <= 19'h00000;                 // see [R22]
                pullup_done_q <= 1'b0;
            end else if (!pullup_done_q) begin
                if (pullup_cnt_q == PULLUP_DELAY - 1)
                    pullup_done_q <= 1'b1;                  // see [R2]
                else
                    pullup_cnt_q <= pullup_cnt_q + 1'b1;
            end
            upstream_pullup_ctrl <= pullup_done_q;          // see [R21]
            upstream_pullup_oe   <= pullup_done_q;          // see [R21]
        end
    end

    // ----------------------------------------
    // Port power and overcurrent handling
    // ----------------------------------------
    // Bus-powered hubs use only the low four ports
    wire [6:0] port_mask = power_source_strap_n ? `MASK_SELF_POWER  // see [R1]
                                                : `MASK_BUS_POWER;  // see [R20]
    wire       any_oc    = |(oc_sticky_q & port_mask);
    wire [6:0] power_d   = ganged_q ?
                           ({7{port_req_q[0] & ~any_oc}} & port_mask) :  // see [R9]
                           (port_req_q & ~oc_sticky_q & port_mask);      // see [R10]

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_sticky_q       <= 7'h00;
            port_power_enable <= 7'h00;
        end else begin
            // A new overcurrent wins over a clear in the same cycle
            if (wr_en && paddr == `REG_OC_STATUS)
                oc_sticky_q <= (oc_sticky_q & ~pwdata[6:0]) | oc_filt;
            else
                oc_sticky_q <= oc_sticky_q | oc_filt;
            // Driven both ways at all times, no pullup needed
            port_power_enable <= power_d & ~oc_filt & ~{7{ganged_q & |oc_filt}}; // see [R8] [R12]
        end
    end

    // ----------------------------------------
    // Clock selection and suspend
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_clock_select       <= 1'b0;
            clock_multiplier_pll_pd <= 1'b0;
            oscillator_pd           <= 1'b0;
            suspend_status_out      <= 1'b0;
        end else begin
            core_clock_select       <= clock_mode_strap;                 // see [R13] [R14]
            // Suspend saves power only by stopping the clock sources
            clock_multiplier_pll_pd <= clock_mode_strap | ctrl_q[`CTRL_SUSPEND]; // see [R14] [R16]
            oscillator_pd           <= clock_mode_strap | ctrl_q[`CTRL_SUSPEND]; // see [R14] [R16]
            // Board must hold an external oscillator low while this is high
            suspend_status_out      <= ctrl_q[`CTRL_SUSPEND];            // see [R16] [R15]
        end
    end

    // ----------------------------------------
    // Indicators and per-port slew
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hub_configured_led <= 1'b0;
            port_power_led     <= 1'b0;
            port_disabled_led  <= 1'b0;
            slow_slew_enable   <= 7'h00;
        end else begin
            hub_configured_led <= ctrl_q[`CTRL_HUB_CFG];                 // see [R19] [R17]
            port_power_led     <= |port_power_enable;                    // see [R17]
            port_disabled_led  <= |((port_dis_q | oc_sticky_q) & port_mask); // see [R17]
            slow_slew_enable   <= low_speed_attached & port_mask;        // see [R18]
        end
    end

    // ----------------------------------------
    // APB register file
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= `CTRL_RESET;
            port_req_q <= `PORTS_RESET;
            port_dis_q <= `PORTS_RESET;
        end else if (wr_en) begin
            case (paddr)
                `REG_CTRL:         ctrl_q     <= {1'b0, pwdata[2:0]};
                `REG_PORT_POWER:   port_req_q <= pwdata[6:0];
                `REG_PORT_DISABLE: port_dis_q <= pwdata[6:0];
                default:           ctrl_q     <= ctrl_q;
            endcase
        end
    end

    always @* begin
        rdata_d = 32'h00000000;
        rerr_d  = 1'b0;
        case (paddr)
            `REG_CTRL:         rdata_d[2:0] = ctrl_q[2:0];
            `REG_PORT_POWER:   rdata_d[6:0] = port_req_q;
            `REG_PORT_DISABLE: rdata_d[6:0] = port_dis_q;
            `REG_OC_STATUS:    rdata_d[6:0] = oc_sticky_q;
            `REG_OC_LIVE:      rdata_d[6:0] = oc_filt;
            `REG_STATUS: begin
                rdata_d[`ST_SELF_POWERED] = power_source_strap_n;
                rdata_d[`ST_EXT_MEMORY_DISABLE_STRAP_OFF]   = ext_memory_disable_strap;
                rdata_d[`ST_CLOCK_MODE]   = clock_mode_strap;
                rdata_d[`ST_GANGED]       = ganged_q;
                rdata_d[`ST_PULLUP_ON]    = pullup_done_q;
                rdata_d[`ST_EE_DONE]      = ee_done;
                rdata_d[`ST_EE_BUSY]      = ee_busy;
                rdata_d[10:8]             = power_source_strap_n ? `COUNT_SELF_POWER
                                                                 : `COUNT_BUS_POWER; // see [R1]
            end
            `REG_IDENT: begin
                if (ext_on && ee_done)
                    rdata_d = {ee_words[31:16], ee_words[47:32]};  // see [R5]
                else
                    rdata_d = {DEFAULT_PID, DEFAULT_VID};          // see [R3]
            end
            default:           rerr_d = 1'b1;
        endcase
    end

    // One wait state: ready comes on the second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & rerr_d;
            prdata  <= (psel & penable & ~pready & ~pwrite) ? rdata_d : 32'h00000000;
        end
    end
endmodule

// *** shared/hub_ctrl_consts.vh ***
// Constants for the hub strap, port power and clock control block
`ifndef HUB_CTRL_CONSTS_VH
`define HUB_CTRL_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CTRL          8'h00
`define REG_PORT_POWER    8'h04
`define REG_PORT_DISABLE  8'h08
`define REG_OC_STATUS     8'h0C
`define REG_STATUS        8'h10
`define REG_IDENT         8'h14
`define REG_OC_LIVE       8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_HUB_CFG      0
`define CTRL_SUSPEND      1
`define CTRL_EE_RELEASE   2
`define CTRL_EE_RELOAD    3
`define ST_SELF_POWERED   0
`define ST_EXT_MEMORY_DISABLE_STRAP_OFF     1
`define ST_CLOCK_MODE     2
`define ST_GANGED         3
`define ST_PULLUP_ON      4
`define ST_EE_DONE        5
`define ST_EE_BUSY        6

// ----------------------------------------
// Reset values and port counts
// ----------------------------------------
`define CTRL_RESET        4'h0
`define PORTS_RESET       7'h00
`define MASK_SELF_POWER   7'h7F
`define MASK_BUS_POWER    7'h0F
`define COUNT_SELF_POWER  3'h7
`define COUNT_BUS_POWER   3'h4

// ----------------------------------------
// Timing
// ----------------------------------------
`define PCLK_HZ           25000000
`define PCLK_PERIOD_NS    40
`define PULLUP_DELAY_MS   15
`define PULLUP_DELAY_CYC  (`PULLUP_DELAY_MS * (`PCLK_HZ / 1000))
`define OC_FILTER_NS      2000
`define OC_FILTER_CYC     ((`OC_FILTER_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)
`define EE_HALF_NS        2000
`define EE_HALF_CYC       (`EE_HALF_NS / `PCLK_PERIOD_NS)
`define EE_CMD_BITS       9
`define EE_CMD_READ0      9'h180
`define EE_DATA_BITS      48

`endif

// *** rtl/overcurrent_filter.v ***
// Glitch filter for one active-low overcurrent input
`include "hub_ctrl_consts.vh"

module overcurrent_filter #(
    parameter CNT_W = 8
) (
    input  wire pclk,      // Clock
    input  wire presetn,   // Async reset, active low
    input  wire oc_in_n,   // Raw overcurrent, active low
    output reg  oc_q       // Filtered overcurrent, active high
);
    reg [CNT_W-1:0] cnt_q;

    // Output follows the input only after it has held for the whole filter time
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= {CNT_W{1'b0}};
            oc_q  <= 1'b0;
        end else if ((~oc_in_n) == oc_q) begin
            cnt_q <= {CNT_W{1'b0}};
        end else if (cnt_q == `OC_FILTER_CYC - 1) begin
            cnt_q <= {CNT_W{1'b0}};
            oc_q  <= ~oc_in_n; // see [R11]
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

// *** rtl/eeprom_reader.v ***
// Serial EEPROM reader for vendor, product and gang settings
`include "hub_ctrl_consts.vh"

module eeprom_reader (
    input  wire        pclk,       // Clock
    input  wire        presetn,    // Async reset, active low
    input  wire        start,      // Begin a load, one cycle
    input  wire        release_bus,// Float both pins for sharing
    input  wire        data_i,     // Serial data in
    output reg         ser_clk_q,  // Serial clock out
    output reg         clk_oe_q,   // Serial clock drive enable
    output reg         data_o_q,   // Serial data out
    output reg         data_oe_q,  // Serial data drive enable
    output reg         busy_q,     // Load in progress
    output reg         done_q,     // Load finished
    output reg  [47:0] words_q     // Vendor, product, gang word
);
    localparam ST_IDLE = 2'b00;
    localparam ST_CMD  = 2'b01;
    localparam ST_READ = 2'b10;

    reg [1:0] state_q;
    reg [7:0] div_q;
    reg [5:0] bit_q;
    reg [8:0] cmd_q;
    wire      tick = (div_q == `EE_HALF_CYC - 1);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= ST_IDLE;
            div_q     <= 8'h00;
            bit_q     <= 6'h00;
            cmd_q     <= 9'h000;
            ser_clk_q <= 1'b0;
            clk_oe_q  <= 1'b0;
            data_o_q  <= 1'b0;
            data_oe_q <= 1'b0;
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
            words_q   <= 48'h000000000000;
        end else begin
            div_q <= tick ? 8'h00 : div_q + 1'b1;
            case (state_q)
                ST_IDLE: begin
                    ser_clk_q <= 1'b0;
                    data_oe_q <= 1'b0;
                    clk_oe_q  <= ~release_bus; // see [R7]
                    if (start && !release_bus) begin
                        state_q  <= ST_CMD;
                        busy_q   <= 1'b1;
                        done_q   <= 1'b0;
                        cmd_q    <= `EE_CMD_READ0;
                        bit_q    <= 6'h00;
                        clk_oe_q <= 1'b1;
                    end
                end
                ST_CMD: if (tick) begin
                    ser_clk_q <= ~ser_clk_q;
                    if (!ser_clk_q) begin
                        data_o_q  <= cmd_q[8];
                        data_oe_q <= 1'b1;
                        cmd_q     <= {cmd_q[7:0], 1'b0};
                    end else if (bit_q == `EE_CMD_BITS - 1) begin
                        bit_q     <= 6'h00;
                        data_oe_q <= 1'b0;
                        state_q   <= ST_READ;
                    end else begin
                        bit_q <= bit_q + 1'b1;
                    end
                end
                ST_READ: if (tick) begin
                    ser_clk_q <= ~ser_clk_q;
                    // Sample on the rising serial clock edge
                    if (!ser_clk_q) begin
                        words_q <= {words_q[46:0], data_i};
                        if (bit_q == `EE_DATA_BITS - 1) begin
                            state_q <= ST_IDLE;
                            busy_q  <= 1'b0;
                            done_q  <= 1'b1;
                        end else begin
                            bit_q <= bit_q + 1'b1;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// *** tb/hub_ctrl_monitor.sv ***
// Checker for pullup, port power and clock select outputs
module hub_ctrl_monitor #(
    parameter int PULLUP_DELAY = 20
) (
    input wire logic       pclk,                    // Clock
    input wire logic       presetn,                 // Reset
    input wire logic       power_source_strap_n,    // Power strap
    input wire logic       clock_mode_strap,        // Clock strap
    input wire logic [6:0] overcurrent_in_n,        // Overcurrent
    input wire logic [6:0] port_power_enable,       // Enables
    input wire logic       upstream_pullup_ctrl,    // Pullup
    input wire logic       upstream_pullup_oe,      // Pullup drive
    input wire logic       core_clock_select,       // Clock select
    input wire logic       clock_multiplier_pll_pd, // Multiplier off
    input wire logic       oscillator_pd,           // Oscillator off
    input wire logic       suspend_status_out,      // Suspend
    input wire logic       port_power_led           // Power LED
);
    int unsigned oc_cnt_q;
    // Length of the current overcurrent episode, to judge the filter from outside
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) oc_cnt_q <= 0;
        else oc_cnt_q <= (&overcurrent_in_n) ? 0 : oc_cnt_q + 1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence strap_flip;
        $changed(power_source_strap_n);
    endsequence
    a_pullup_paired: assert property (upstream_pullup_ctrl == upstream_pullup_oe)
        else $error("pullup level and drive differ");
    a_pullup_restart: assert property (strap_flip |-> ##[1:4] !upstream_pullup_oe)
        else $error("pullup not withdrawn after strap change");
    a_pullup_delay: assert property ($rose(upstream_pullup_oe)
        |-> $past(upstream_pullup_oe, PULLUP_DELAY) == 1'b0) else $error("pullup delay short");
    a_bus_mask: assert property (!power_source_strap_n [*4]
        |-> port_power_enable[6:4] == 3'h0) else $error("upper ports powered in bus-powered mode");
    a_oc_drop: assert property (oc_cnt_q == 55
        |-> (port_power_enable & ~overcurrent_in_n) == 7'h00) else $error("port powered under oc");
    a_suspend_pd: assert property (suspend_status_out
        |-> clock_multiplier_pll_pd && oscillator_pd) else $error("clock sources alive in suspend");
    a_clock_direct: assert property (clock_mode_strap [*3]
        |-> core_clock_select && clock_multiplier_pll_pd && oscillator_pd) else $error("direct clock");
    a_power_led: assert property ($stable(port_power_enable) [*2]
        |-> port_power_led == |port_power_enable) else $error("power LED wrong");
endmodule

// *** tb/eeprom_model.sv ***
// Serial EEPROM model that serves one identifier image after nine clocks, whatever the command bits
module eeprom_model #(
    parameter logic [47:0] IMAGE = 48'h2468_9BDF_0000
) (
    input wire logic sclk,  // Clock as seen on the pin
    input wire logic rst_n, // Power-on reset
    output logic     q,     // Data out
    output logic     q_oe   // Data drive enable
);
    int n;
    always @(posedge sclk or negedge rst_n) begin
        if (!rst_n) n <= 0;
        else n <= n + 1;
    end
    // Data moves on the falling edge so it is settled at the next rising sample
    always @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            q_oe <= 1'b0;
            q <= 1'b0;
        end else begin
            q_oe <= n >= 9 && n < 57;
            q <= (n >= 9 && n < 57) ? IMAGE[56 - n] : ~q;
        end
    end
endmodule

// *** tb/hub_strap_power_clock_ctrl_tb.sv ***
// Self-checking bench for the hub strap, port power and clock control block
module hub_strap_power_clock_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int          PULLUP_DELAY = 20;
    localparam logic [15:0] VENDOR_IDENTIFIER = 16'h1A2B; // Arbitrary value
    localparam logic [15:0] PRODUCT_IDENTIFIER = 16'h3C4D; // Arbitrary value
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, m_q, m_oe;
    logic        pwr_n, ext_strap, clk_strap, gang_sel, ee_clk, ee_coe, ee_do, ee_doe, pu, pu_oe;
    logic        clk_sel, pll_pd, osc_pd, susp, led_cfg, led_pwr, led_dis;
    logic [6:0]  oc_n, low_speed, ppe, slew;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    wire         ee_dq;
    int          fail_count = 0, comparisons = 0;
    logic [40:0] rows [6] = '{{8'h14, 32'h9BDF2468, 1'b0}, {8'h10, 32'h00000731, 1'b0},
        {8'h18, 32'h00000000, 1'b0}, {8'h1C, 32'h00000000, 1'b1},
        {8'h00, 32'h00000000, 1'b0}, {8'h04, 32'h00000000, 1'b0}};
    hub_strap_power_clock_ctrl #(.PULLUP_DELAY(PULLUP_DELAY), .DEFAULT_VID(VENDOR_IDENTIFIER),
        .DEFAULT_PID(PRODUCT_IDENTIFIER)) dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .power_source_strap_n(pwr_n), .ext_memory_disable_strap(ext_strap),
        .clock_mode_strap(clk_strap), .overcurrent_in_n(oc_n), .low_speed_attached(low_speed),
        .eeprom_serial_clock(ee_clk), .eeprom_serial_clock_oe(ee_coe), .eeprom_serial_data_o(ee_do),
        .eeprom_serial_data_oe(ee_doe), .eeprom_serial_data_i(ee_dq), .port_power_enable(ppe),
        .upstream_pullup_ctrl(pu), .upstream_pullup_oe(pu_oe), .core_clock_select(clk_sel),
        .clock_multiplier_pll_pd(pll_pd), .oscillator_pd(osc_pd), .suspend_status_out(susp),
        .hub_configured_led(led_cfg), .port_power_led(led_pwr), .port_disabled_led(led_dis),
        .slow_slew_enable(slew));
    // Undriven data pin carries the gang select strap level
    assign ee_dq = ee_doe ? ee_do : m_oe ? m_q : gang_sel;
    eeprom_model mem (.sclk(ee_clk & ee_coe), .rst_n(presetn), .q(m_q), .q_oe(m_oe));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        close_out();
    end
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Entered just after a rising edge; settles three edges so outputs are seen updated
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        repeat (3) @(posedge pclk);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {pwr_n, ext_strap, clk_strap, gang_sel, oc_n, low_speed} = {4'h8, 7'h7F, 7'h41};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        while (r[5] !== 1'b1) begin
            repeat (100) @(posedge pclk);
            apb(1'b0, 8'h10, '0);
        end
        foreach (rows[i]) begin
            apb(1'b0, rows[i][40:33], '0);
            chk({r, e}, rows[i][32:0]);
        end
        apb(1'b1, 8'h04, 32'h7F);
        chk(ppe, 7'h7F);
        oc_n <= 7'h5F;
        repeat (10) @(posedge pclk);
        oc_n <= 7'h7F;
        repeat (60) @(posedge pclk);
        chk(ppe, 7'h7F);
        oc_n <= 7'h7B;
        repeat (60) @(posedge pclk);
        chk(ppe, 7'h7B);
        oc_n <= 7'h7F;
        apb(1'b1, 8'h00, 32'h3);
        chk({led_cfg, susp, pll_pd, osc_pd, led_pwr, led_dis, clk_sel}, 7'h7E);
        apb(1'b1, 8'h00, 32'h4);
        chk({ee_coe, ee_doe, susp}, 3'h0);
        pwr_n <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(pu_oe, 1'b0);
        repeat (30) @(posedge pclk);
        chk({pu, pu_oe, ppe, slew}, {2'h3, 7'h0B, 7'h01});
        presetn <= 1'b0;
        {pwr_n, ext_strap, clk_strap, gang_sel} <= 4'hF;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h14, '0);
        chk(r, {PRODUCT_IDENTIFIER, VENDOR_IDENTIFIER});
        apb(1'b1, 8'h04, 32'h1);
        chk({ee_coe, ee_doe, clk_sel, ppe}, {3'h1, 7'h7F});
        oc_n <= 7'h3F;
        repeat (60) @(posedge pclk);
        chk(ppe, 7'h00);
        close_out();
    end
endmodule
bind hub_strap_power_clock_ctrl hub_ctrl_monitor #(.PULLUP_DELAY(PULLUP_DELAY)) mon (.*);
